// >>> sar_adc_parallel_output.v
// Summary of operation
// - result pins driven inverted, one reads low
// - unipolar straight, bipolar offset binary, both inverted
// - result settled before status falls
// - result bits change on gated clock rise
// - one LSB in gives FFFE code
// - full scale minus two gives 0001 code
// - half scale gives 7FFF code
// - status set on start, cleared at end
// - gated clock runs 17 cycles, then low
// - bits resolved MSB first, one per period
`timescale 1ns/100ps
`include "sar_defs.vh"

module sar_adc_parallel_output #(
  parameter WIDTH = `SAR_WIDTH,
  parameter GATED_CYCLES = `SAR_GATED_CYCLES
) (
  input wire clock,
  input wire sys_rst,
  input wire convert_start,
  input wire cmp_above,
  input wire bipolar_sel,
  output reg [WIDTH-1:0] result_pins,
  output reg status,
  output reg gated_clk,
  output reg bipolar_flag
);
  localparam ST_IDLE = 3'b001;
  localparam ST_ARM = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [5:0] cyc_r;
  reg [WIDTH-1:0] sel_r;
  reg start_d_r;
  wire [WIDTH-1:0] true_bits;
  wire start_trail;
  wire rise;
  wire init;

  // start is acted on at its trailing edge
  assign start_trail = start_d_r && !convert_start;
  assign init = (state_r == ST_ARM);
  // gated clock rises when the low half ends
  assign rise = (state_r == ST_RUN) && !gated_clk;

  sar_bit_cell #(.WIDTH(WIDTH)) u_bits (
    .clock(clock),
    .sys_rst(sys_rst),
    .init(init),
    .step(rise && (cyc_r != 6'h00)),
    .trial_sel(sel_r),
    .cmp_keep(!cmp_above),
    .true_bits(true_bits)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_trail) begin
          state_nxt = ST_ARM;
        end
      end
      ST_ARM: begin
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!rise && cyc_r == GATED_CYCLES[5:0]) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      start_d_r <= 1'b0;
      cyc_r <= 6'h00;
      sel_r <= {WIDTH{1'b0}};
      status <= 1'b0;
      gated_clk <= 1'b0;
      result_pins <= {WIDTH{1'b1}};
      bipolar_flag <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_d_r <= convert_start;
      if (start_trail && state_r == ST_IDLE) begin
        status <= 1'b1;
        bipolar_flag <= bipolar_sel;
      end
      if (init) begin
        cyc_r <= 6'h00;
        sel_r <= {1'b1, {(WIDTH-1){1'b0}}};
        gated_clk <= 1'b0;
      end else if (state_r == ST_RUN) begin
        if (rise) begin
          gated_clk <= 1'b1;
          cyc_r <= cyc_r + 6'h01;
          if (cyc_r != 6'h00) begin
            sel_r <= sel_r >> 1;
          end
        end else begin
          gated_clk <= 1'b0;
          if (cyc_r == GATED_CYCLES[5:0]) begin
            // result already stood one full clock period before this
            status <= 1'b0;
          end
        end
      end else begin
        gated_clk <= 1'b0;
      end
      // pins follow the sar only at arm and at gated clock rises; both ranges invert
      if (rise || init) begin
        result_pins <= ~(init ? {1'b1, {(WIDTH-1){1'b0}}} : true_bits);
      end
    end
  end
  // codes FFFE/0001/7FFF arise from inversion of the true value
endmodule

// >>> sar_defs.vh
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH

`define SAR_WIDTH 16
`define SAR_GATED_CYCLES 17
`define SAR_CLK_PERIOD_NS 25
`define SAR_VALID_MARGIN_NS 20
`define SAR_VALID_MARGIN_CYC ((`SAR_VALID_MARGIN_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_HALF_PERIODS 2
`define SAR_CAL_LSB_CODE 16'hFFFE
`define SAR_CAL_FS_CODE 16'h0001
`define SAR_CAL_MID_CODE 16'h7FFF

`endif

// >>> sar_bit_cell.v
`timescale 1ns/100ps
`include "sar_defs.vh"

module sar_bit_cell #(
  parameter WIDTH = `SAR_WIDTH
) (
  input wire clock,
  input wire sys_rst,
  input wire init,
  input wire step,
  input wire [WIDTH-1:0] trial_sel,
  input wire cmp_keep,
  output wire [WIDTH-1:0] true_bits
);
  reg [WIDTH-1:0] bits_r;
  wire [WIDTH-1:0] bits_nxt;
  // bit just below the one under trial gets the next trial
  wire [WIDTH-1:0] below_sel;
  assign below_sel = {1'b0, trial_sel[WIDTH-1:1]};
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign bits_nxt[i] = init ? ((i == WIDTH - 1) ? 1'b1 : 1'b0) :
                           (step && trial_sel[i]) ? cmp_keep :
                           (step && below_sel[i]) ? 1'b1 :
                           bits_r[i];
    end
  endgenerate
  always @(posedge clock) begin
    if (sys_rst) begin
      bits_r <= {WIDTH{1'b0}};
    end else begin
      bits_r <= bits_nxt;
    end
  end
  // next value, so the pins take a decision at the same rise that makes it
  assign true_bits = bits_nxt;
endmodule

// >>> sar_props_properties.sv
`timescale 1ns/100ps
module sar_props #(parameter GATED_CYCLES = 17) (
  input wire clock,
  input wire sys_rst,
  input wire convert_start,
  input wire bipolar_sel,
  input wire [15:0] result_pins,
  input wire status,
  input wire gated_clk,
  input wire bipolar_flag);
  reg [4:0] n_r;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_go; $fell(convert_start) && !status; endsequence
  always @(posedge clock) n_r <= (sys_rst || !status) ? 5'h00 : n_r + {4'h0, gated_clk};
  a_go_busy: assert property (s_go |-> ##[1:2] status) else $error("no busy");
  a_busy_span: assert property ($rose(status) |-> status[*8]) else $error("short");
  a_clk_idle: assert property (!status |-> !gated_clk) else $error("clk idle");
  a_clk_count: assert property ($fell(status) |-> n_r == GATED_CYCLES) else $error("pulses");
  a_init_code: assert property ($rose(status) |-> ##[1:2] result_pins == 16'h7FFF)
    else $error("init");
  a_pins_still: assert property (!$stable(result_pins) |-> status) else $error("idle pin");
  a_data_early: assert property ($fell(status) |-> $stable(result_pins)) else $error("late");
  a_range_flag: assert property ($fell(status) |-> bipolar_flag == bipolar_sel)
    else $error("range");
endmodule
bind sar_adc_parallel_output sar_props #(.GATED_CYCLES(GATED_CYCLES)) sar_props_i (.*);

// >>> sar_host_model.sv
`timescale 1ns/100ps
module sar_host_model (
  input wire clock,
  input wire status,
  input wire [15:0] result_pins,
  input wire [15:0] target,
  output wire cmp_above,
  output reg [15:0] captured);
  reg busy_r = 1'b0;
  assign cmp_above = target < ~result_pins;
  always @(posedge clock) begin
    busy_r <= status;
    if (busy_r && !status) captured <= ~result_pins;
  end
endmodule

// >>> sar_adc_parallel_output_tb_top.sv
`timescale 1ns/100ps
module sar_adc_parallel_output_tb_top;
  reg clock = 1'b0, sys_rst = 1'b1, convert_start = 1'b0, bipolar_sel = 1'b0;
  reg [15:0] target = 16'h0000;
  integer seed = 32'h4152BC66, n_fail = 0, num_checks = 0, i, k, rnd;
  wire cmp_above, status, gated_clk, bipolar_flag;
  wire [15:0] result_pins, captured;
  always #12.5 clock = ~clock;
  sar_adc_parallel_output sar_adc_parallel_output_i (.*);
  sar_host_model sar_host_model_i (.*);
  function [15:0] exp_pins(input [15:0] t); return ~t; endfunction
  task chk(input [15:0] got, input [15:0] exp);
    num_checks++;
    n_fail += (got !== exp);
    if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
  endtask
  task end_sim;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task conv(input [15:0] t);
    rnd = $random(seed);
    target <= t;
    bipolar_sel <= rnd[9];
    convert_start <= 1'b1;
    // a second start while busy must be ignored
    for (k = 0; k < 60 && !(k > 4 && status === 1'b0); k++) begin
      @(posedge clock);
      convert_start <= (k == 9);
    end
    n_fail += (k == 60);
    if (k == 60) end_sim;
    else begin
      repeat (2) @(posedge clock);
      chk(captured, t);
      chk(result_pins, exp_pins(t));
      chk(result_pins ^ 16'h8000, ~(t ^ 16'h8000));
      chk({15'h0000, bipolar_flag}, {15'h0000, bipolar_sel});
    end
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    conv(16'h0001);
    conv(16'hFFFE);
    conv(16'h8000);
    for (i = 0; i < 20; i++) begin
      rnd = $random(seed);
      conv(rnd[15:0]);
    end
    end_sim;
  end
endmodule
